// File: hdl/rco_regs.v
// Serial register bank for RC calibration, self-test and one-time store
//
// Notes on behaviour
// - Any strobe write launches calibration when enabled and no run is busy
// - Strobe starts self-test when mode bit set
// - Fifteen-bit reference period in picoseconds
// - Signed correction added before code decode
// - Correction LSB equals 1.024 ns
// - Calibrated fine code limited to zero through eleven
// - Calibration busy at status bit four
// - Raw 24-bit count before correction readable
// - Mirror shows stored parameter bits
// - Stored values used only when programmed flag
// - Pulse write programs bit when enabled
// - Store write busy at status bit five
// - Signature and busy bit sixteen readable
// - Calibration runs only while enabled
// - Override bit selects host fine code
`timescale 1ns/1ps
`include "rco_defines.vh"

module rco_regs (
    input wire mclk,
    input wire rstn,
    input wire sclk,
    input wire sen_n,
    input wire sdi,
    output reg sdo_ff,
    output reg sdo_oe_ff,
    input wire ref_clk,
    input wire rc_cmp,
    input wire cal_enable,
    input wire force_cal_code,
    input wire [`RCO_CODE_W-1:0] force_fine_code,
    input wire use_stored_values_ctrl,
    output reg rc_charge_ff,
    output reg [`RCO_CODE_W-1:0] active_fine_code_ff,
    output reg stored_active_ff,
    output reg [`RCO_NV_BITS-1:0] nv_mirror_ff,
    output reg nv_fuse_pulse_ff
);
    localparam NPIN = 5;
    localparam P_SCLK = 0;
    localparam P_SEN = 1;
    localparam P_SDI = 2;
    localparam P_REF = 3;
    localparam P_RC = 4;
    localparam integer NV_CYC_INT = `RCO_NV_PROG_CYC;
    localparam [`RCO_NV_CNT_W-1:0] NV_CYC = NV_CYC_INT[`RCO_NV_CNT_W-1:0];

    reg [1:0] rst_sync_ff;
    wire rst_n = rst_sync_ff[1];

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_ff <= 2'b00;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    // Pin conditioning: three stages, change taken when stages two and three agree
    wire [NPIN-1:0] pin_in = {rc_cmp, ref_clk, sdi, sen_n, sclk};
    wire [NPIN-1:0] filt_ff;
    wire [NPIN-1:0] filt_d_ff;
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1)
        begin : g_pin
            // Reset to the pin's idle level so no false edge follows reset
            reg [2:0] sync_ff;
            reg level_ff;
            reg level_d_ff;
            always @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    sync_ff <= (g == P_SEN) ? 3'b111 : 3'b000;
                    level_ff <= (g == P_SEN) ? 1'b1 : 1'b0;
                    level_d_ff <= (g == P_SEN) ? 1'b1 : 1'b0;
                end
                else
                begin
                    sync_ff <= {sync_ff[1:0], pin_in[g]};
                    if (sync_ff[1] == sync_ff[2])
                        level_ff <= sync_ff[2];
                    level_d_ff <= level_ff;
                end
            end
            assign filt_ff[g] = level_ff;
            assign filt_d_ff[g] = level_d_ff;
        end
    endgenerate

    wire sclk_rise = filt_ff[P_SCLK] & ~filt_d_ff[P_SCLK];
    wire sclk_fall = ~filt_ff[P_SCLK] & filt_d_ff[P_SCLK];
    wire frame_on = ~filt_ff[P_SEN];
    wire ref_tick = filt_ff[P_REF] & ~filt_d_ff[P_REF];
    wire sdi_bit = filt_ff[P_SDI];

    // Serial frame state
    reg [`RCO_BITCNT_W-1:0] bitcnt_ff;
    reg [`RCO_DATA_W+`RCO_FRAME_HDR-2:0] shift_ff;
    reg [`RCO_DATA_W-1:0] rd_sh_ff;
    reg rd_mode_ff;

    // Register contents
    reg [`RCO_PERIOD_W-1:0] ref_period_ff;
    reg [`RCO_CORR_W-1:0] correction_ff;
    reg nv_program_enable_ff;
    reg [`RCO_NV_ADDR_W-1:0] nv_addr_ff;
    reg selftest_mode_enable_ff;
    reg [`RCO_NV_BITS-1:0] nv_store_ff;
    reg nv_write_active_ff;
    reg [`RCO_NV_CNT_W-1:0] nv_cnt_ff;
    reg [`RCO_NV_ADDR_W-1:0] nv_target_ff;
    reg cal_start_ff;
    reg nv_start_ff;

    wire eng_busy;
    wire eng_test;
    wire eng_charge;
    wire [`RCO_DATA_W-1:0] eng_raw;
    wire [`RCO_CODE_W-1:0] eng_code;
    wire [`RCO_SIG_W-1:0] eng_sig;

    wire cal_busy = eng_busy & ~eng_test;
    wire selftest_busy = eng_busy & eng_test;
    wire [`RCO_ADDR_W-1:0] hdr_addr = shift_ff[`RCO_ADDR_W-1:0];
    wire [`RCO_ADDR_W-1:0] wr_addr = shift_ff[`RCO_DATA_W+`RCO_ADDR_W-2:`RCO_DATA_W-1];
    wire [`RCO_DATA_W-1:0] wr_data = {shift_ff[`RCO_DATA_W-2:0], sdi_bit};
    wire wr_rd_bit = shift_ff[`RCO_DATA_W+`RCO_ADDR_W-1];
    wire hdr_done = sclk_rise && bitcnt_ff == `RCO_FRAME_HDR - 1;
    wire wr_fire = frame_on && sclk_rise && bitcnt_ff == `RCO_FRAME_LAST && !wr_rd_bit;

    reg [`RCO_DATA_W-1:0] rd_data;

    always @*
    begin
        rd_data = {`RCO_DATA_W{1'b0}};
        case (hdr_addr)
            `RCO_OFS_REF_PERIOD: rd_data[`RCO_PERIOD_W-1:0] = ref_period_ff;
            `RCO_OFS_CORRECTION: rd_data[`RCO_CORR_W-1:0] = correction_ff;
            `RCO_OFS_CAL_STATUS:
            begin
                rd_data[`RCO_CODE_W-1:0] = eng_code;
                rd_data[`RCO_STAT_CAL_BUSY] = cal_busy;
                rd_data[`RCO_STAT_NV_BUSY] = nv_write_active_ff;
            end
            `RCO_OFS_RAW_COUNT: rd_data = eng_raw;
            `RCO_OFS_NV_MIRROR: rd_data[`RCO_NV_BITS-1:0] = nv_store_ff;
            `RCO_OFS_NV_ENABLE: rd_data[0] = nv_program_enable_ff;
            `RCO_OFS_NV_ADDR: rd_data[`RCO_NV_ADDR_W-1:0] = nv_addr_ff;
            `RCO_OFS_ST_MODE: rd_data[0] = selftest_mode_enable_ff;
            `RCO_OFS_ST_RESULT:
            begin
                // Signature is only meaningful once the busy bit has cleared
                rd_data[`RCO_SIG_W-1:0] = eng_sig;
                rd_data[`RCO_ST_BUSY_BIT] = selftest_busy;
            end
            default: rd_data = {`RCO_DATA_W{1'b0}};
        endcase
    end

    // Serial shifter
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bitcnt_ff <= {`RCO_BITCNT_W{1'b0}};
            shift_ff <= {(`RCO_DATA_W+`RCO_FRAME_HDR-1){1'b0}};
            rd_sh_ff <= {`RCO_DATA_W{1'b0}};
            rd_mode_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else if (!frame_on)
        begin
            bitcnt_ff <= {`RCO_BITCNT_W{1'b0}};
            rd_mode_ff <= 1'b0;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else
        begin
            if (sclk_rise && bitcnt_ff <= `RCO_FRAME_LAST)
            begin
                shift_ff <= {shift_ff[`RCO_DATA_W+`RCO_FRAME_HDR-3:0], sdi_bit};
                bitcnt_ff <= bitcnt_ff + 1'b1;
            end
            if (hdr_done)
            begin
                // Header completes on this edge; direction bit is now shift_ff[5]
                rd_mode_ff <= shift_ff[`RCO_ADDR_W-1];
            end
            if (sclk_rise && bitcnt_ff == `RCO_FRAME_HDR && rd_mode_ff)
                rd_sh_ff <= rd_data;
            // Data goes out on falling edges so it is settled at the host's rising edge
            if (sclk_fall && rd_mode_ff && bitcnt_ff > `RCO_FRAME_HDR - 1)
            begin
                sdo_ff <= (bitcnt_ff == `RCO_FRAME_HDR) ? rd_data[`RCO_DATA_W-1]
                                                         : rd_sh_ff[`RCO_DATA_W-1];
                if (bitcnt_ff != `RCO_FRAME_HDR)
                    rd_sh_ff <= {rd_sh_ff[`RCO_DATA_W-2:0], 1'b0};
                sdo_oe_ff <= 1'b1;
            end
        end
    end

    // Register writes and strobes
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_period_ff <= `RCO_RST_PERIOD;
            correction_ff <= `RCO_RST_CORR;
            nv_program_enable_ff <= 1'b0;
            nv_addr_ff <= `RCO_RST_NV_ADDR;
            selftest_mode_enable_ff <= 1'b0;
            cal_start_ff <= 1'b0;
            nv_start_ff <= 1'b0;
        end
        else
        begin
            cal_start_ff <= 1'b0;
            nv_start_ff <= 1'b0;
            if (wr_fire)
            begin
                case (wr_addr)
                    `RCO_OFS_CAL_STROBE:
                        // Written value is dropped; a strobe during a run is lost
                        cal_start_ff <= cal_enable & ~eng_busy;
                    `RCO_OFS_REF_PERIOD: ref_period_ff <= wr_data[`RCO_PERIOD_W-1:0];
                    `RCO_OFS_CORRECTION: correction_ff <= wr_data[`RCO_CORR_W-1:0];
                    `RCO_OFS_NV_ENABLE: nv_program_enable_ff <= wr_data[0];
                    `RCO_OFS_NV_ADDR: nv_addr_ff <= wr_data[`RCO_NV_ADDR_W-1:0];
                    `RCO_OFS_NV_PULSE:
                        nv_start_ff <= nv_program_enable_ff & ~nv_write_active_ff;
                    `RCO_OFS_ST_MODE: selftest_mode_enable_ff <= wr_data[0];
                    default: cal_start_ff <= 1'b0;
                endcase
            end
        end
    end

    // One-time store: a bit can only be set, never cleared except by reset
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_store_ff <= {`RCO_NV_BITS{1'b0}};
            nv_write_active_ff <= 1'b0;
            nv_cnt_ff <= {`RCO_NV_CNT_W{1'b0}};
            nv_target_ff <= `RCO_RST_NV_ADDR;
            nv_fuse_pulse_ff <= 1'b0;
        end
        else if (nv_start_ff)
        begin
            nv_write_active_ff <= 1'b1;
            nv_fuse_pulse_ff <= 1'b1;
            nv_cnt_ff <= NV_CYC;
            nv_target_ff <= nv_addr_ff;
        end
        else if (nv_write_active_ff)
        begin
            if (nv_cnt_ff == {{(`RCO_NV_CNT_W-1){1'b0}}, 1'b1})
            begin
                nv_store_ff[nv_target_ff] <= 1'b1;
                nv_write_active_ff <= 1'b0;
                nv_fuse_pulse_ff <= 1'b0;
            end
            nv_cnt_ff <= nv_cnt_ff - 1'b1;
        end
    end

    rco_cal_engine u_engine (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cal_enable),
        .start(cal_start_ff),
        .test_mode(selftest_mode_enable_ff),
        .ref_tick(ref_tick),
        .rc_done(filt_ff[P_RC]),
        .period(ref_period_ff),
        .correction(correction_ff),
        .busy_ff(eng_busy),
        .test_ff(eng_test),
        .charge_ff(eng_charge),
        .raw_ff(eng_raw),
        .code_ff(eng_code),
        .sig_ff(eng_sig)
    );

    // Filter-facing outputs
    wire stored_ok = nv_store_ff[`RCO_NV_PRG_FLAG] & use_stored_values_ctrl;
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rc_charge_ff <= 1'b0;
            active_fine_code_ff <= {`RCO_CODE_W{1'b0}};
            stored_active_ff <= 1'b0;
            nv_mirror_ff <= {`RCO_NV_BITS{1'b0}};
        end
        else
        begin
            rc_charge_ff <= eng_charge;
            stored_active_ff <= stored_ok;
            nv_mirror_ff <= nv_store_ff;
            if (force_cal_code)
                active_fine_code_ff <= force_fine_code;
            else if (stored_ok)
                active_fine_code_ff <= nv_store_ff[`RCO_NV_FINE_LSB+`RCO_CODE_W-1:`RCO_NV_FINE_LSB];
            else
                active_fine_code_ff <= eng_code;
        end
    end
endmodule // rco_regs

// File: hdl/rco_defines.vh
// Constants for the RC calibration and one-time store register block
`ifndef RCO_DEFINES_VH
`define RCO_DEFINES_VH

// Register offsets (serial port addresses)
`define RCO_ADDR_W 6
`define RCO_OFS_CAL_STROBE 6'h04
`define RCO_OFS_REF_PERIOD 6'h05
`define RCO_OFS_CORRECTION 6'h06
`define RCO_OFS_CAL_STATUS 6'h08
`define RCO_OFS_RAW_COUNT 6'h09
`define RCO_OFS_NV_MIRROR 6'h0a
`define RCO_OFS_NV_ENABLE 6'h0b
`define RCO_OFS_NV_ADDR 6'h0c
`define RCO_OFS_NV_PULSE 6'h0d
`define RCO_OFS_ST_MODE 6'h0e
`define RCO_OFS_ST_RESULT 6'h0f

// Register widths and field layout
`define RCO_DATA_W 24
`define RCO_PERIOD_W 15
`define RCO_CORR_W 9
`define RCO_CODE_W 4
`define RCO_NV_ADDR_W 4
`define RCO_NV_BITS 16
`define RCO_SIG_W 16
`define RCO_STAT_CAL_BUSY 4
`define RCO_STAT_NV_BUSY 5
`define RCO_ST_BUSY_BIT 16
`define RCO_NV_PRG_FLAG 13
`define RCO_NV_FINE_LSB 0

// Reset values
`define RCO_RST_PERIOD 15'h0000
`define RCO_RST_CORR 9'h000
`define RCO_RST_NV_ADDR 4'h0
`define RCO_RST_SIG 16'h0000

// Serial frame: one direction bit, six address bits, 24 data bits
`define RCO_FRAME_HDR 7
`define RCO_FRAME_LAST 6'h1e
`define RCO_BITCNT_W 6

// Correction step is 1.024 ns, so one LSB is 1024 ps: shift by ten
`define RCO_CORR_STEP_PS 1024
`define RCO_CORR_SHIFT 10
`define RCO_SUM_W 26
// Corrected count bits that form the fine code; 4.096 ns per code
`define RCO_CODE_LSB 12
`define RCO_CODE_MAX 4'hb
`define RCO_RAW_MAX 24'hffffff

// Self-test uses a synthetic RC end after this many reference periods
`define RCO_ST_TICKS 16'h0040
`define RCO_TICK_W 16
`define RCO_CRC_INIT 16'hffff
`define RCO_CRC_POLY 16'h1021

// Timing of one store programming operation
`define RCO_CLK_PERIOD_PS 8000
`define RCO_NV_PROG_TIME_NS 10000
`define RCO_NV_PROG_CYC ((`RCO_NV_PROG_TIME_NS * 1000 + `RCO_CLK_PERIOD_PS - 1) / `RCO_CLK_PERIOD_PS)
`define RCO_NV_CNT_W 20

// Engine states
`define RCO_ST_IDLE 2'h0
`define RCO_ST_MEAS 2'h1
`define RCO_ST_CORR 2'h2
`define RCO_ST_SIGN 2'h3

`endif

// File: hdl/rco_cal_engine.v
// RC calibration engine: measure, correct, decode, optional signature
`timescale 1ns/1ps
`include "rco_defines.vh"

module rco_cal_engine (
    input wire mclk,
    input wire rst_n,
    input wire enable,
    input wire start,
    input wire test_mode,
    input wire ref_tick,
    input wire rc_done,
    input wire [`RCO_PERIOD_W-1:0] period,
    input wire [`RCO_CORR_W-1:0] correction,
    output reg busy_ff,
    output reg test_ff,
    output reg charge_ff,
    output reg [`RCO_DATA_W-1:0] raw_ff,
    output reg [`RCO_CODE_W-1:0] code_ff,
    output reg [`RCO_SIG_W-1:0] sig_ff
);
    localparam [1:0] S_IDLE = `RCO_ST_IDLE;
    localparam [1:0] S_MEAS = `RCO_ST_MEAS;
    localparam [1:0] S_CORR = `RCO_ST_CORR;
    localparam [1:0] S_SIGN = `RCO_ST_SIGN;

    reg [1:0] state_ff;
    reg [`RCO_TICK_W-1:0] tick_ff;
    wire [`RCO_DATA_W:0] acc = {1'b0, raw_ff} + {10'h000, period};
    wire signed [`RCO_SUM_W-1:0] corr_sum = {2'b00, raw_ff}
        + {{7{correction[`RCO_CORR_W-1]}}, correction, 10'h000};
    wire too_big = |corr_sum[`RCO_SUM_W-2:`RCO_CODE_LSB+`RCO_CODE_W];
    wire [`RCO_CODE_W-1:0] raw_code = corr_sum[`RCO_CODE_LSB+`RCO_CODE_W-1:`RCO_CODE_LSB];
    wire meas_end = test_ff ? (tick_ff == `RCO_ST_TICKS) : rc_done;

    function [`RCO_SIG_W-1:0] crc_step;
        input [`RCO_SIG_W-1:0] crc;
        input [`RCO_DATA_W+`RCO_CODE_W-1:0] data;
        integer i;
        reg [`RCO_SIG_W-1:0] c;
        begin
            c = crc;
            for (i = `RCO_DATA_W + `RCO_CODE_W - 1; i >= 0; i = i - 1)
            begin
                if (c[`RCO_SIG_W-1] ^ data[i])
                    c = {c[`RCO_SIG_W-2:0], 1'b0} ^ `RCO_CRC_POLY;
                else
                    c = {c[`RCO_SIG_W-2:0], 1'b0};
            end
            crc_step = c;
        end
    endfunction

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= S_IDLE;
            busy_ff <= 1'b0;
            test_ff <= 1'b0;
            charge_ff <= 1'b0;
            tick_ff <= {`RCO_TICK_W{1'b0}};
            raw_ff <= {`RCO_DATA_W{1'b0}};
            code_ff <= {`RCO_CODE_W{1'b0}};
            sig_ff <= `RCO_RST_SIG;
        end
        else if (!enable)
        begin
            // Dropping the enable aborts a run; results keep their last value
            state_ff <= S_IDLE;
            busy_ff <= 1'b0;
            charge_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    if (start)
                    begin
                        state_ff <= S_MEAS;
                        busy_ff <= 1'b1;
                        test_ff <= test_mode;
                        charge_ff <= 1'b1;
                        tick_ff <= {`RCO_TICK_W{1'b0}};
                        raw_ff <= {`RCO_DATA_W{1'b0}};
                    end
                end
                S_MEAS:
                begin
                    // Accumulating the period per tick avoids a 24x15 multiplier
                    if (meas_end || raw_ff == `RCO_RAW_MAX)
                    begin
                        state_ff <= S_CORR;
                        charge_ff <= 1'b0;
                    end
                    else if (ref_tick)
                    begin
                        tick_ff <= tick_ff + 1'b1;
                        raw_ff <= acc[`RCO_DATA_W] ? `RCO_RAW_MAX : acc[`RCO_DATA_W-1:0];
                    end
                end
                S_CORR:
                begin
                    if (corr_sum[`RCO_SUM_W-1])
                        code_ff <= {`RCO_CODE_W{1'b0}};
                    else if (too_big || raw_code > `RCO_CODE_MAX)
                        code_ff <= `RCO_CODE_MAX;
                    else
                        code_ff <= raw_code;
                    if (test_ff)
                        state_ff <= S_SIGN;
                    else
                    begin
                        state_ff <= S_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
                S_SIGN:
                begin
                    sig_ff <= crc_step(`RCO_CRC_INIT, {code_ff, raw_ff});
                    state_ff <= S_IDLE;
                    busy_ff <= 1'b0;
                end
                default:
                begin
                    state_ff <= S_IDLE;
                    busy_ff <= 1'b0;
                end
            endcase
        end
    end
endmodule // rco_cal_engine

// File: sim/rco_regs_asserts.sv
// Port-level checks of the RC calibration register block
`timescale 1ns/1ps
`include "rco_defines.vh"

module rco_regs_asserts (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rc_cmp,
    input wire logic cal_enable,
    input wire logic force_cal_code,
    input wire logic [`RCO_CODE_W-1:0] force_fine_code,
    input wire logic use_stored_values_ctrl,
    input wire logic rc_charge_ff,
    input wire logic [`RCO_CODE_W-1:0] active_fine_code_ff,
    input wire logic stored_active_ff,
    input wire logic [`RCO_NV_BITS-1:0] nv_mirror_ff,
    input wire logic nv_fuse_pulse_ff
);
    logic [11:0] prog_cnt_ff;
    logic [11:0] nxt_prog_cnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Width of one store pulse, in mclk cycles
    assign nxt_prog_cnt = nv_fuse_pulse_ff ? prog_cnt_ff + 12'h001 : 12'h000;
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            prog_cnt_ff <= 12'h000;
        else
            prog_cnt_ff <= nxt_prog_cnt;
    end

    sequence prog_start;
        $rose(nv_fuse_pulse_ff);
    endsequence
    sequence prog_end;
        $fell(nv_fuse_pulse_ff);
    endsequence

    prog_hold_a: assert property (prog_start |-> nv_fuse_pulse_ff[*8])
        else $error("store pulse dropped early");
    prog_len_a: assert property (prog_end |-> prog_cnt_ff >= 1249 && prog_cnt_ff <= 1251)
        else $error("store pulse width wrong");
    // One-time store only gains bits, and only at the end of a pulse
    mirror_grow_a: assert property (!$stable(nv_mirror_ff) |->
        ($past(nv_mirror_ff) & ~nv_mirror_ff) == 16'h0000
        && ($past(nv_fuse_pulse_ff) || $past(nv_fuse_pulse_ff, 2)))
        else $error("store bits changed outside a pulse");
    stored_on_a: assert property ((use_stored_values_ctrl && nv_mirror_ff[13])[*2]
        |-> stored_active_ff) else $error("stored values not used");
    stored_off_a: assert property ((!nv_mirror_ff[13])[*2] |-> !stored_active_ff)
        else $error("stored values used while unprogrammed");
    override_code_a: assert property ((force_cal_code && $stable(force_fine_code))[*3]
        |-> active_fine_code_ff == force_fine_code) else $error("override code ignored");
    code_range_a: assert property ((!force_cal_code)[*2] |-> active_fine_code_ff <= 4'hb)
        else $error("fine code above eleven");
    enable_stop_a: assert property ((!cal_enable)[*3] |-> !rc_charge_ff)
        else $error("measurement while disabled");
    rc_end_a: assert property (rc_cmp[*7] |-> !rc_charge_ff)
        else $error("measurement kept after end");
endmodule // rco_regs_asserts

// File: sim/rco_spi_host.sv
// Serial host model: 32-clock frames, data sampled on sclk rising
`timescale 1ns/1ps

module rco_spi_host (
    input wire logic mclk,
    input wire logic sdo,
    output logic sclk,
    output logic sen_n,
    output logic sdi
);
    initial
    begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdi = 1'b0;
    end

    // Slow sclk: the pin filter plus sdo shift need several mclk per half
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [23:0] wd,
        output logic [23:0] rdata);
        logic [31:0] frame;
        frame = {rd, a, wd, 1'b0};
        rdata = 24'h000000;
        @(posedge mclk) sen_n <= 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk) sdi <= frame[31-i];
            repeat (8) @(posedge mclk);
            if (i >= 8)
                rdata = {rdata[22:0], sdo};
            sclk <= 1'b1;
            repeat (8) @(posedge mclk);
            sclk <= 1'b0;
        end
        @(posedge mclk) sen_n <= 1'b1;
        sdi <= ~sdi;
        repeat (12) @(posedge mclk);
    endtask
endmodule // rco_spi_host

// File: sim/rco_regs_tb_top.sv
// Self-checking bench for the RC calibration register block
`timescale 1ns/1ps
`include "rco_defines.vh"
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end

module rco_regs_tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ref_clk = 1'b0;
    logic rc_cmp = 1'b0;
    logic cal_enable = 1'b0;
    logic force_cal_code = 1'b0;
    logic [3:0] force_fine_code = 4'h0;
    logic use_stored_values_ctrl = 1'b0;
    wire sclk, sen_n, sdi, sdo_ff, sdo_oe_ff, rc_charge_ff, stored_active_ff, nv_fuse_pulse_ff;
    wire [3:0] active_fine_code_ff;
    wire [15:0] nv_mirror_ff;
    int fails = 0;
    int comparisons = 0;

    always #4 mclk = ~mclk;

    rco_regs rco_regs_i (.mclk(mclk), .rstn(rstn), .sclk(sclk), .sen_n(sen_n), .sdi(sdi),
        .sdo_ff(sdo_ff), .sdo_oe_ff(sdo_oe_ff), .ref_clk(ref_clk), .rc_cmp(rc_cmp),
        .cal_enable(cal_enable), .force_cal_code(force_cal_code),
        .force_fine_code(force_fine_code), .use_stored_values_ctrl(use_stored_values_ctrl),
        .rc_charge_ff(rc_charge_ff), .active_fine_code_ff(active_fine_code_ff),
        .stored_active_ff(stored_active_ff), .nv_mirror_ff(nv_mirror_ff),
        .nv_fuse_pulse_ff(nv_fuse_pulse_ff));
    rco_spi_host rco_spi_host_i (.mclk(mclk), .sdo(sdo_ff), .sclk(sclk), .sen_n(sen_n),
        .sdi(sdi));

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] unused;
        rco_spi_host_i.xfer(1'b0, a, d, unused);
    endtask

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [23:0] exp,
        input logic [23:0] mask);
        logic [23:0] got;
        rco_spi_host_i.xfer(1'b1, a, 24'h000000, got);
        `CHK(what, exp & mask, got & mask)
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            @(posedge mclk) ref_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            ref_clk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask

    function automatic logic [15:0] crc16(input logic [27:0] d);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 27; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction

    task automatic t_reset_widths;
        logic [5:0] ra [10] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h0a, 6'h0b, 6'h0c, 6'h0e,
            6'h0f, 6'h10};
        logic [5:0] a [6] = '{6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0e, 6'h04};
        logic [23:0] e [6] = '{24'h007fff, 24'h0001ff, 24'h000001, 24'h00000f, 24'h000001,
            24'h000000};
        foreach (ra[i]) rd_chk("reset value", ra[i], 24'h000000, 24'hffffff);
        foreach (a[i]) wr(a[i], 24'hffffff);
        foreach (a[i]) rd_chk("field width", a[i], e[i], 24'hffffff);
        foreach (a[i]) wr(a[i], 24'h000000);
        wr(6'h3f, 24'hffffff);
        rd_chk("unmapped", 6'h3f, 24'h000000, 24'hffffff);
        rd_chk("disabled start", `RCO_OFS_ST_RESULT, 24'h0, 24'h010000);
    endtask

    // Extra strobe mid-run must not restart the count: raw stays three periods
    task automatic cal_case(input logic [23:0] corr, input logic [3:0] code);
        wr(`RCO_OFS_CORRECTION, corr);
        wr(`RCO_OFS_CAL_STROBE, 24'h000001);
        rd_chk("cal busy", `RCO_OFS_CAL_STATUS, 24'h000010, 24'h000030);
        ticks(1);
        wr(`RCO_OFS_CAL_STROBE, 24'hffffff);
        ticks(2);
        @(posedge mclk) rc_cmp <= 1'b1;
        repeat (10) @(posedge mclk);
        rc_cmp <= 1'b0;
        rd_chk("fine code", `RCO_OFS_CAL_STATUS, {20'h0, code}, 24'hffffff);
        rd_chk("raw count", `RCO_OFS_RAW_COUNT, 24'h003c00, 24'hffffff);
        `CHK("active code", code, active_fine_code_ff)
    endtask

    task automatic t_selftest;
        wr(`RCO_OFS_CORRECTION, 24'h000000);
        wr(`RCO_OFS_ST_MODE, 24'h000001);
        wr(`RCO_OFS_CAL_STROBE, 24'h000000);
        rd_chk("selftest busy", `RCO_OFS_ST_RESULT, 24'h010000, 24'h010000);
        rd_chk("no cal busy", `RCO_OFS_CAL_STATUS, 24'h000000, 24'h000010);
        ticks(64);
        repeat (40) @(posedge mclk);
        rd_chk("signature", `RCO_OFS_ST_RESULT, {8'h0, crc16({4'hb, 24'h050000})},
            24'hffffff);
        wr(`RCO_OFS_ST_MODE, 24'h000000);
    endtask

    task automatic t_override;
        @(posedge mclk) force_cal_code <= 1'b1;
        force_fine_code <= 4'h9;
        repeat (4) @(negedge mclk);
        `CHK("override code", 4'h9, active_fine_code_ff)
        @(posedge mclk) force_cal_code <= 1'b0;
    endtask

    task automatic t_store;
        @(posedge mclk) use_stored_values_ctrl <= 1'b1;
        wr(`RCO_OFS_NV_ADDR, 24'h00000d);
        wr(`RCO_OFS_NV_PULSE, 24'h000001);
        rd_chk("store idle", `RCO_OFS_CAL_STATUS, 24'h000000, 24'h000020);
        `CHK("stored unused", 1'b0, stored_active_ff)
        wr(`RCO_OFS_NV_ENABLE, 24'h000001);
        wr(`RCO_OFS_NV_PULSE, 24'h000001);
        rd_chk("store busy", `RCO_OFS_CAL_STATUS, 24'h000020, 24'h000020);
        for (int i = 0; i < 2000 && nv_fuse_pulse_ff; i++)
            @(posedge mclk);
        rd_chk("store mirror", `RCO_OFS_NV_MIRROR, 24'h002000, 24'hffffff);
        `CHK("mirror port", 16'h2000, nv_mirror_ff)
        `CHK("stored used", 1'b1, stored_active_ff)
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        repeat (10) @(posedge mclk);
        t_reset_widths();
        @(posedge mclk) cal_enable <= 1'b1;
        wr(`RCO_OFS_REF_PERIOD, 24'h001400);
        cal_case(24'h000000, 4'h3);
        cal_case(24'h0001fd, 4'h3);
        cal_case(24'h0001fc, 4'h2);
        cal_case(24'h000100, 4'h0);
        cal_case(24'h0000ff, 4'hb);
        wr(`RCO_OFS_RAW_COUNT, 24'habcdef);
        rd_chk("raw read-only", `RCO_OFS_RAW_COUNT, 24'h003c00, 24'hffffff);
        wr(`RCO_OFS_CAL_STROBE, 24'h000000);
        @(posedge mclk) cal_enable <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK("abort charge", 1'b0, rc_charge_ff)
        rd_chk("abort busy", `RCO_OFS_CAL_STATUS, 24'h00000b, 24'h00001f);
        @(posedge mclk) cal_enable <= 1'b1;
        t_selftest();
        t_override();
        t_store();
        report_and_stop();
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        fails++;
        report_and_stop();
    end
endmodule // rco_regs_tb_top

bind rco_regs rco_regs_asserts rco_regs_asserts_i (.mclk(mclk), .rstn(rstn), .rc_cmp(rc_cmp),
    .cal_enable(cal_enable), .force_cal_code(force_cal_code),
    .force_fine_code(force_fine_code), .use_stored_values_ctrl(use_stored_values_ctrl),
    .rc_charge_ff(rc_charge_ff), .active_fine_code_ff(active_fine_code_ff),
    .stored_active_ff(stored_active_ff), .nv_mirror_ff(nv_mirror_ff),
    .nv_fuse_pulse_ff(nv_fuse_pulse_ff));
